// ===== hostport_map.svh
// offsets, field positions, reset values and counts of the host port
// assumes inclusion by both ends; holds definitions only
`ifndef HOSTPORT_MAP_SVH
`define HOSTPORT_MAP_SVH
// device register byte offsets on the host bus
`define HP_OFS_IRQ 9'h1E8
`define HP_OFS_IO_CONTROL_REGISTER 9'h1EC
`define HP_OFS_STAT 9'h1F0
`define HP_OFS_HOLD 9'h1F4
// io control fields, in the least significant byte
`define HP_IO_CONTROL_REGISTER_BLIND 0
`define HP_IO_CONTROL_REGISTER_RDY 1
`define HP_IO_CONTROL_REGISTER_MCU 2
`define HP_IO_CONTROL_REGISTER_RESET 3'h0
`define HP_IRQ_INVALID 0
// completion flag as seen in every byte lane
`define HP_DONE_BYTE 8'h80
`define HP_DUMMY_BYTE 8'h00
// bus clock edge counts; core latency and bclk half period are in clk_in cycles
`define HP_WAIT_EDGE 5'h02
`define HP_ABORT_EDGES 5'h11
`define HP_HOST_FAIL_EDGES 5'h14
`define HP_HOST_WS_RESET 5'h04
`define HP_CORE_LATENCY 40
`define HP_BCLK_HALF 4
// controller register offsets on apb
`define HP_APB_CMD 12'h000
`define HP_APB_CFG 12'h004
`define HP_APB_STATUS 12'h008
`define HP_CFG_HS_RESET 1'h1
`endif

// ===== hostport_pkg.sv
// state types of both ends of the host port
// assumes nothing beyond the compile order
package hostport_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE = 3'b001,
		DEV_BUSY = 3'b010,
		DEV_END = 3'b100
	} dev_state_t;
	typedef enum logic [2:0] {
		HOST_IDLE = 3'b001,
		HOST_ACTIVE = 3'b010,
		HOST_RELEASE = 3'b100
	} host_state_t;
endpackage

// ===== hostport_if.sv
// pins between the host controller and the device host port
// assumes an external pull-up on the shared wait line
`timescale 1ns/1ps
interface hostport_if;
	logic bclk;
	logic chip_select_n;
	logic read_not_write;
	logic [8:0] addr;
	logic [15:0] host_data;
	logic host_data_oe;
	logic [15:0] dev_data;
	logic dev_data_oe;
	logic host_wait_n_o;
	logic host_wait_n_oe;
	logic irq;
	logic host_wait_n;
	logic [15:0] data;
	// resolved wire levels; pull-up on wait, float reads as ones
	assign host_wait_n = host_wait_n_oe ? host_wait_n_o : 1'b1;
	assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'hFFFF);
	modport dev(input bclk, chip_select_n, read_not_write, addr, data, host_wait_n,
		output dev_data, dev_data_oe, host_wait_n_o, host_wait_n_oe, irq);
	modport host(output bclk, chip_select_n, read_not_write, addr, host_data, host_data_oe,
		input data, host_wait_n, irq);
endinterface

// ===== hostport_dev.sv
// device end of the host port: wait handshake, byte lanes, blind access
// assumes all pins come from another domain and bclk is below clk_in / 4
// Contract
// - write byte taken at first bclk rise
// - release wait when ready to end write
// - read: release wait, data off at cs rise
// - abort and release after 17 bclk edges
// - host drops wait after 20 low edges
// - wait asserted on second edge after start
// - host programs four or more wait states; the cfg write takes any value 0-31 unchecked
// - wait pin open-drain or push-pull by bit
// - interrupt always driven, write one clears
// - media mode bytes on bits 0-7
// - controller mode bytes on bits 8-15
// - controller mode always blind
// - blind enable bit selects blind mode
// - blind access gives no acknowledge
// - blind read result in holding register
// - done flag in bits 7,15,23,31
// - done flag set only when finished
// - first blind read returns dummy
// - early access aborted, raises invalid interrupt
// - status or holding read clears flag
`timescale 1ns/1ps
`include "hostport_map.svh"
module hostport_dev #(
	parameter int WORDS = 16,
	parameter int CORE_LATENCY = `HP_CORE_LATENCY
) (
	// clock and control
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// pins toward the host
	hostport_if.dev bus,
	// user-side status
	output logic blind_mode_out,
	output logic done_flag_out
);
	localparam int IW = $clog2(WORDS);
	if (WORDS < 2 || WORDS > 128 || (WORDS & (WORDS - 1)) != 0 ||
		CORE_LATENCY < 1 || CORE_LATENCY > 255) begin : g_chk
		$error("hostport_dev: unsupported parameters");
	end

	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
		case (i)
			2'h0: byte_of = w[31:24];
			2'h1: byte_of = w[23:16];
			2'h2: byte_of = w[15:8];
			default: byte_of = w[7:0];
		endcase
	endfunction

	function automatic logic [15:0] lane(input logic m, input logic [7:0] b);
		lane = m ? {b, 8'h00} : {8'h00, b};
	endfunction

	function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] i,
		input logic [7:0] b);
		logic [31:0] r;
		r = w;
		case (i)
			2'h0: r[31:24] = b;
			2'h1: r[23:16] = b;
			2'h2: r[15:8] = b;
			default: r[7:0] = b;
		endcase
		put_byte = r;
	endfunction

	hostport_pkg::dev_state_t state_reg;
	logic [2:0] bclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] rw_sync_reg;
	logic [8:0] addr_s1_reg, addr_s2_reg;
	logic [15:0] data_s1_reg, data_s2_reg;
	logic [4:0] edge_cnt_reg;
	logic wait_low_reg, drv_reg, core_wait_reg, op_rd_reg;
	logic [1:0] op_idx_reg;
	logic [15:0] dev_data_reg;
	logic eng_busy_reg, eng_wr_reg, eng_done_reg;
	logic [7:0] eng_cnt_reg;
	logic [IW-1:0] eng_idx_reg;
	logic [31:0] eng_wdata_reg, eng_rdata_reg;
	logic [31:0] core_mem [WORDS];
	logic pend_reg, done_flag_reg, inv_irq_reg;
	logic [31:0] holding_reg, wbuf_reg;
	logic [3:0] wmask_reg;
	logic [6:0] wquad_reg;
	logic [2:0] io_control_register_reg;
	logic rise, start_ev, rd, mcu, blind, is_stat, is_hold, is_io_control_register, is_irq, is_local;
	logic abort_ev, local_ev, target_ev, launch, hs_release, hs_abort, eng_last;
	logic [1:0] idx;
	logic [7:0] wr_byte;
	logic [3:0] mask_new;
	logic [31:0] wword, local_word;

	// pin synchronisers; third bclk stage only feeds the edge detector
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			bclk_sync_reg <= 3'h0;
			cs_sync_reg <= 2'h3;
			rw_sync_reg <= 2'h3;
			addr_s1_reg <= 9'h000;
			addr_s2_reg <= 9'h000;
			data_s1_reg <= 16'h0000;
			data_s2_reg <= 16'h0000;
		end else if (ce_in) begin
			bclk_sync_reg <= {bclk_sync_reg[1:0], bus.bclk};
			cs_sync_reg <= {cs_sync_reg[0], bus.chip_select_n};
			rw_sync_reg <= {rw_sync_reg[0], bus.read_not_write};
			addr_s1_reg <= bus.addr;
			addr_s2_reg <= addr_s1_reg;
			data_s1_reg <= bus.data;
			data_s2_reg <= data_s1_reg;
		end
	end

	// access decode at the first bclk rise inside chip select
	assign rise = bclk_sync_reg[1] & ~bclk_sync_reg[2];
	assign start_ev = ce_in & rise & ~cs_sync_reg[1] & (state_reg == hostport_pkg::DEV_IDLE);
	assign rd = rw_sync_reg[1];
	assign idx = addr_s2_reg[1:0];
	assign mcu = io_control_register_reg[`HP_IO_CONTROL_REGISTER_MCU];
	assign blind = io_control_register_reg[`HP_IO_CONTROL_REGISTER_BLIND] | mcu;
	assign is_stat = addr_s2_reg[8:2] == `HP_OFS_STAT >> 2;
	assign is_hold = addr_s2_reg[8:2] == `HP_OFS_HOLD >> 2;
	assign is_io_control_register = addr_s2_reg[8:2] == `HP_OFS_IO_CONTROL_REGISTER >> 2;
	assign is_irq = addr_s2_reg[8:2] == `HP_OFS_IRQ >> 2;
	assign is_local = is_stat | is_hold | is_io_control_register | is_irq;
	assign wr_byte = mcu ? data_s2_reg[15:8] : data_s2_reg[7:0];
	assign abort_ev = start_ev & blind & pend_reg & ~(rd & (is_stat | is_hold));
	assign local_ev = start_ev & ~abort_ev & is_local;
	assign target_ev = start_ev & ~abort_ev & ~is_local;
	assign mask_new = ((addr_s2_reg[8:2] == wquad_reg) ? wmask_reg : 4'h0) | (4'h8 >> idx);
	assign wword = put_byte(wbuf_reg, idx, wr_byte);
	assign launch = target_ev & (rd | (mask_new == 4'hF));
	assign hs_release = ce_in & rise & (state_reg == hostport_pkg::DEV_BUSY) &
		(edge_cnt_reg >= `HP_WAIT_EDGE) & ~core_wait_reg;
	assign hs_abort = ce_in & rise & (state_reg == hostport_pkg::DEV_BUSY) & core_wait_reg &
		(edge_cnt_reg == `HP_ABORT_EDGES - 5'h01);
	assign eng_last = eng_busy_reg & (eng_cnt_reg == 8'h01);
	// status word repeats the done flag in every byte lane
	always_comb begin
		local_word = 32'h0000_0000;
		if (is_stat)
			local_word = {4{done_flag_reg ? `HP_DONE_BYTE : 8'h00}};
		else if (is_hold)
			local_word = holding_reg;
		else if (is_io_control_register)
			local_word = {29'h0, io_control_register_reg};
		else if (is_irq)
			local_word = {31'h0, inv_irq_reg};
	end

	// host-side sequencing; blind accesses skip the wait phase entirely
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= hostport_pkg::DEV_IDLE;
			edge_cnt_reg <= 5'h00;
			wait_low_reg <= 1'b0;
			drv_reg <= 1'b0;
			core_wait_reg <= 1'b0;
			op_rd_reg <= 1'b0;
			op_idx_reg <= 2'h0;
		end else if (ce_in) begin
			case (state_reg)
				hostport_pkg::DEV_IDLE: if (start_ev) begin
					op_rd_reg <= rd;
					op_idx_reg <= idx;
					edge_cnt_reg <= 5'h00;
					core_wait_reg <= launch & ~blind;
					drv_reg <= rd & blind;
					state_reg <= blind ? hostport_pkg::DEV_END : hostport_pkg::DEV_BUSY;
				end
				hostport_pkg::DEV_BUSY: begin
					if (eng_done_reg || hs_abort)
						core_wait_reg <= 1'b0;
					if (rise)
						edge_cnt_reg <= edge_cnt_reg + 5'h01;
					if (rise && edge_cnt_reg == `HP_WAIT_EDGE - 5'h01)
						wait_low_reg <= 1'b1;
					if (hs_release || hs_abort) begin
						wait_low_reg <= 1'b0;
						drv_reg <= op_rd_reg;
						state_reg <= hostport_pkg::DEV_END;
					end
				end
				hostport_pkg::DEV_END: if (cs_sync_reg[1]) begin
					drv_reg <= 1'b0;
					state_reg <= hostport_pkg::DEV_IDLE;
				end
				default: state_reg <= hostport_pkg::DEV_IDLE;
			endcase
		end
	end

	// read data lanes; the other lane is driven low
	always_ff @(posedge clk_in) begin
		if (srst_in)
			dev_data_reg <= 16'h0000;
		else if (ce_in) begin
			if (start_ev && rd)
				dev_data_reg <= lane(mcu, local_ev ? byte_of(local_word, idx) : `HP_DUMMY_BYTE);
			else if (eng_done_reg && core_wait_reg)
				dev_data_reg <= lane(mcu, byte_of(eng_rdata_reg, op_idx_reg));
		end
	end

	// stand-in for the link core: fixed latency, only a handshake abort kills it
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			eng_busy_reg <= 1'b0;
			eng_wr_reg <= 1'b0;
			eng_done_reg <= 1'b0;
			eng_cnt_reg <= 8'h00;
			eng_idx_reg <= '0;
			eng_wdata_reg <= 32'h0000_0000;
			eng_rdata_reg <= 32'h0000_0000;
		end else if (ce_in) begin
			eng_done_reg <= eng_last & ~hs_abort;
			if (launch) begin
				eng_busy_reg <= 1'b1;
				eng_wr_reg <= ~rd;
				eng_idx_reg <= addr_s2_reg[IW+1:2];
				eng_wdata_reg <= wword;
				eng_cnt_reg <= 8'(CORE_LATENCY);
			end else if (hs_abort)
				eng_busy_reg <= 1'b0;
			else if (eng_busy_reg) begin
				eng_cnt_reg <= eng_cnt_reg - 8'h01;
				if (eng_last) begin
					eng_busy_reg <= 1'b0;
					eng_rdata_reg <= core_mem[eng_idx_reg];
				end
			end
		end
	end

	// core storage; data only, so no reset
	always_ff @(posedge clk_in) begin
		if (ce_in && eng_last && eng_wr_reg && !hs_abort)
			core_mem[eng_idx_reg] <= eng_wdata_reg;
	end

	// blind bookkeeping; a finishing core wins over a clearing read
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pend_reg <= 1'b0;
			done_flag_reg <= 1'b0;
			holding_reg <= 32'h0000_0000;
		end else if (ce_in) begin
			if (launch && blind)
				pend_reg <= 1'b1;
			else if (eng_done_reg)
				pend_reg <= 1'b0;
			if (eng_done_reg && !eng_wr_reg)
				holding_reg <= eng_rdata_reg;
			if (eng_done_reg && pend_reg)
				done_flag_reg <= 1'b1;
			else if ((local_ev && rd && (is_stat || is_hold)) || target_ev)
				done_flag_reg <= 1'b0;
		end
	end

	// write stacking; a partial quadlet is dropped by a read or a new quadlet
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wbuf_reg <= 32'h0000_0000;
			wmask_reg <= 4'h0;
			wquad_reg <= 7'h00;
		end else if (ce_in && target_ev) begin
			wbuf_reg <= rd ? wbuf_reg : wword;
			wmask_reg <= (rd || launch) ? 4'h0 : mask_new;
			wquad_reg <= addr_s2_reg[8:2];
		end
	end

	// local registers; invalid access sticks until written with a one
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			io_control_register_reg <= `HP_IO_CONTROL_REGISTER_RESET;
			inv_irq_reg <= 1'b0;
		end else if (ce_in) begin
			if (local_ev && !rd && is_io_control_register && idx == 2'h3)
				io_control_register_reg <= wr_byte[2:0];
			if (abort_ev)
				inv_irq_reg <= 1'b1;
			else if (local_ev && !rd && is_irq && idx == 2'h3 && wr_byte[`HP_IRQ_INVALID])
				inv_irq_reg <= 1'b0;
		end
	end

	// pins; data enable drops at once on chip select rise
	assign bus.dev_data = dev_data_reg;
	assign bus.dev_data_oe = drv_reg & ~bus.chip_select_n;
	assign bus.host_wait_n_o = io_control_register_reg[`HP_IO_CONTROL_REGISTER_RDY] ? ~wait_low_reg : 1'b0;
	assign bus.host_wait_n_oe = io_control_register_reg[`HP_IO_CONTROL_REGISTER_RDY] | wait_low_reg;
	assign bus.irq = inv_irq_reg;
	assign blind_mode_out = blind;
	assign done_flag_out = done_flag_reg;
endmodule

// ===== hostport_host.sv
// host end of the host port: bclk divider, chip select cycles, apb orders
// assumes the device samples pins on its own clock; wait line has a pull-up
`timescale 1ns/1ps
`include "hostport_map.svh"
module hostport_host #(
	parameter int BCLK_HALF = `HP_BCLK_HALF
) (
	// clock and control
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// apb slave
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// pins toward the device
	hostport_if.host bus
);
	if (BCLK_HALF < 2 || BCLK_HALF > 255) begin : g_chk
		$error("hostport_host: unsupported bclk divider");
	end

	hostport_pkg::host_state_t state_reg;
	logic [7:0] div_cnt_reg;
	logic bclk_reg, gap_reg;
	logic [1:0] wait_sync_reg;
	logic [15:0] data_s1_reg, data_s2_reg;
	logic [4:0] ws_reg, edge_cnt_reg, wlow_cnt_reg;
	logic hs_en_reg, mcu_reg, go_reg, ignored_reg, timeout_reg;
	logic [8:0] cmd_addr_reg;
	logic cmd_rd_reg;
	logic [7:0] cmd_wdata_reg, rdata_reg;
	logic cs_n_reg, hdata_oe_reg;
	logic [15:0] hdata_reg;
	logic [31:0] prdata_reg;
	logic tick, rise_ev, fall_ev, busy, wr_en, start, ws_met;

	assign tick = ce_in & (div_cnt_reg == 8'(BCLK_HALF - 1));
	assign rise_ev = tick & ~bclk_reg;
	assign fall_ev = tick & bclk_reg;
	assign busy = go_reg | (state_reg != hostport_pkg::HOST_IDLE);
	assign wr_en = psel_in & penable_in & pwrite_in;
	assign start = go_reg & fall_ev & gap_reg & (state_reg == hostport_pkg::HOST_IDLE);
	assign ws_met = ({1'b0, edge_cnt_reg} + 6'h01) >= {1'b0, ws_reg};

	// bus clock divider, free running
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			div_cnt_reg <= 8'h00;
			bclk_reg <= 1'b0;
		end else if (ce_in) begin
			div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
			bclk_reg <= tick ? ~bclk_reg : bclk_reg;
		end
	end

	// synchronisers for wait and read data
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wait_sync_reg <= 2'h3;
			data_s1_reg <= 16'h0000;
			data_s2_reg <= 16'h0000;
		end else if (ce_in) begin
			wait_sync_reg <= {wait_sync_reg[0], bus.host_wait_n};
			data_s1_reg <= bus.data;
			data_s2_reg <= data_s1_reg;
		end
	end

	// apb registers; a command while busy is dropped
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ws_reg <= `HP_HOST_WS_RESET;
			hs_en_reg <= `HP_CFG_HS_RESET;
			mcu_reg <= 1'b0;
			go_reg <= 1'b0;
			cmd_addr_reg <= 9'h000;
			cmd_rd_reg <= 1'b0;
			cmd_wdata_reg <= 8'h00;
			prdata_reg <= 32'h0000_0000;
		end else if (ce_in) begin
			if (start)
				go_reg <= 1'b0;
			else if (wr_en && paddr_in == `HP_APB_CMD && !busy) begin
				go_reg <= 1'b1;
				cmd_wdata_reg <= pwdata_in[7:0];
				cmd_addr_reg <= pwdata_in[24:16];
				cmd_rd_reg <= pwdata_in[31];
			end
			if (wr_en && paddr_in == `HP_APB_CFG) begin
				ws_reg <= pwdata_in[4:0];
				hs_en_reg <= pwdata_in[5];
				mcu_reg <= pwdata_in[6];
			end
			if (psel_in && !penable_in) begin
				case (paddr_in)
					`HP_APB_CMD: prdata_reg <= {cmd_rd_reg, 6'h00, cmd_addr_reg, 8'h00,
						cmd_wdata_reg};
					`HP_APB_CFG: prdata_reg <= {25'h0, mcu_reg, hs_en_reg, ws_reg};
					`HP_APB_STATUS: prdata_reg <= {16'h0, rdata_reg, 5'h00, timeout_reg,
						ignored_reg, busy};
					default: prdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// chip select cycle; wait is counted only while honoured
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= hostport_pkg::HOST_IDLE;
			gap_reg <= 1'b0;
			edge_cnt_reg <= 5'h00;
			wlow_cnt_reg <= 5'h00;
			cs_n_reg <= 1'b1;
			hdata_oe_reg <= 1'b0;
			hdata_reg <= 16'h0000;
			ignored_reg <= 1'b0;
			timeout_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else if (ce_in) begin
			case (state_reg)
				hostport_pkg::HOST_IDLE: begin
					if (rise_ev)
						gap_reg <= 1'b1;
					if (start) begin
						gap_reg <= 1'b0;
						cs_n_reg <= 1'b0;
						hdata_oe_reg <= ~cmd_rd_reg;
						hdata_reg <= mcu_reg ? {cmd_wdata_reg, 8'h00} : {8'h00, cmd_wdata_reg};
						edge_cnt_reg <= 5'h00;
						wlow_cnt_reg <= 5'h00;
						timeout_reg <= 1'b0;
						state_reg <= hostport_pkg::HOST_ACTIVE;
					end
				end
				hostport_pkg::HOST_ACTIVE: if (rise_ev) begin
					edge_cnt_reg <= (edge_cnt_reg == 5'h1F) ? edge_cnt_reg : edge_cnt_reg + 5'h01;
					if (hs_en_reg && !ignored_reg && !wait_sync_reg[1]) begin
						wlow_cnt_reg <= wlow_cnt_reg + 5'h01;
						if (wlow_cnt_reg == `HP_HOST_FAIL_EDGES) begin
							ignored_reg <= 1'b1;
							timeout_reg <= 1'b1;
							cs_n_reg <= 1'b1;
							hdata_oe_reg <= 1'b0;
							state_reg <= hostport_pkg::HOST_IDLE;
						end
					end else if (ws_met) begin
						rdata_reg <= mcu_reg ? data_s2_reg[15:8] : data_s2_reg[7:0];
						if (cmd_rd_reg) begin
							cs_n_reg <= 1'b1;
							state_reg <= hostport_pkg::HOST_IDLE;
						end else
							state_reg <= hostport_pkg::HOST_RELEASE;
					end
				end
				hostport_pkg::HOST_RELEASE: if (fall_ev) begin
					cs_n_reg <= 1'b1;
					hdata_oe_reg <= 1'b0;
					state_reg <= hostport_pkg::HOST_IDLE;
				end
				default: state_reg <= hostport_pkg::HOST_IDLE;
			endcase
		end
	end

	// pins and bus answers; zero wait state apb
	assign bus.bclk = bclk_reg;
	assign bus.chip_select_n = cs_n_reg;
	assign bus.read_not_write = cmd_rd_reg;
	assign bus.addr = cmd_addr_reg;
	assign bus.host_data = hdata_reg;
	assign bus.host_data_oe = hdata_oe_reg;
	assign prdata_out = prdata_reg;
	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
endmodule

// ===== hostport_monitor.sv
// pin checks on the host port between the two ends
// assumes bclk is divided from clk_in and ready drive stays open-drain
`timescale 1ns/1ps
module hostport_monitor (
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// watched pins
	input wire logic bclk,
	input wire logic chip_select_n,
	input wire logic read_not_write,
	input wire logic [15:0] host_data,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic host_wait_n_o,
	input wire logic host_wait_n_oe,
	input wire logic host_wait_n
);
	logic bclk_reg;
	logic [4:0] wait_rises_reg;
	logic [3:0] cs_rises_reg;
	// previous bclk level for edge finding
	always_ff @(posedge clk_in) begin
		bclk_reg <= bclk;
	end
	// bclk rises seen while wait held low
	always_ff @(posedge clk_in) begin
		if (srst_in || host_wait_n)
			wait_rises_reg <= 5'h00;
		else if (bclk && !bclk_reg)
			wait_rises_reg <= wait_rises_reg + 5'h01;
	end
	// bclk rises seen inside the chip select window, saturating
	always_ff @(posedge clk_in) begin
		if (srst_in || chip_select_n)
			cs_rises_reg <= 4'h0;
		else if (bclk && !bclk_reg && cs_rises_reg != 4'hF)
			cs_rises_reg <= cs_rises_reg + 4'h1;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	AST_WAIT_BOUND: assert property (wait_rises_reg <= 5'h11)
		else $error("wait held low past the abort limit");
	AST_DATA_OFF_CS: assert property (chip_select_n |-> !dev_data_oe)
		else $error("device drives data while deselected");
	AST_NO_CONTENTION: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	AST_WAIT_IN_CS: assert property ($fell(host_wait_n) |-> !chip_select_n)
		else $error("wait asserted outside chip select");
	AST_WAIT_SECOND: assert property ($fell(host_wait_n) |-> cs_rises_reg == 4'h3)
		else $error("wait not asserted on the second edge");
	AST_OPEN_DRAIN: assert property (host_wait_n_oe |-> !host_wait_n_o)
		else $error("wait driven high in open-drain mode");
	AST_CS_RD: assert property ($rose(host_wait_n) && !chip_select_n && read_not_write
		|-> ##[1:16] chip_select_n)
		else $error("read cycle not ended after wait release");
	AST_CS_WR: assert property ($rose(host_wait_n) && !chip_select_n && !read_not_write
		|-> ##[1:16] chip_select_n)
		else $error("write cycle not ended after wait release");
	AST_DATA_STABLE: assert property (!chip_select_n && !read_not_write
		&& !$past(chip_select_n) |-> $stable(host_data))
		else $error("write data moved inside the cycle");
endmodule

// ===== host_port_wait_blind_access_tb.sv
// self-checking bench: apb orders to the host end, device end on the pins
// assumes default parameters, so bclk is 320 ns
`timescale 1ns/1ps
`include "hostport_map.svh"
module host_port_wait_blind_access_tb;
	logic clk_in, srst_in, psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, st;
	logic pready_out, pslverr_out, blind_mode_out, done_flag_out, wait_seen;
	logic [15:0] dev_seen;
	int err_total, n_checks;
	hostport_if intf();
	hostport_dev hostport_dev_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
		.bus(intf.dev), .blind_mode_out(blind_mode_out), .done_flag_out(done_flag_out));
	hostport_host hostport_host_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
		.paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .bus(intf.host));
	hostport_monitor hostport_monitor_i (.clk_in(clk_in), .srst_in(srst_in),
		.bclk(intf.bclk), .chip_select_n(intf.chip_select_n),
		.read_not_write(intf.read_not_write), .host_data(intf.host_data),
		.host_data_oe(intf.host_data_oe), .dev_data_oe(intf.dev_data_oe),
		.host_wait_n_o(intf.host_wait_n_o), .host_wait_n_oe(intf.host_wait_n_oe),
		.host_wait_n(intf.host_wait_n));
	// 25 MHz system clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// last device drive and any wait assertion, for lane and blind checks
	always @(posedge clk_in) begin
		if (intf.dev_data_oe === 1'b1) dev_seen <= intf.data;
		if (intf.host_wait_n === 1'b0) wait_seen <= 1'b1;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	// one pin cycle, then status polled until the host is idle
	task automatic op(input logic rd, input logic [8:0] a, input logic [7:0] b);
		apb(1'b1, `HP_APB_CMD, {rd, 6'h00, a, 8'h00, b}, st);
		st = 32'h1;
		while (st[0] !== 1'b0) apb(1'b0, `HP_APB_STATUS, 32'h0, st);
	endtask
	// blind status lane read until the done byte shows
	task automatic poll(input logic [8:0] a);
		op(1'b1, a, 8'h00);
		while (st[15:8] !== `HP_DONE_BYTE) op(1'b1, a, 8'h00);
	endtask
	// handshake writes fill a quadlet, reads come back in the low lane
	task automatic t_handshake;
		wait_seen = 1'b0;
		for (int i = 0; i < 4; i++) op(1'b0, 9'h020 + 9'(i), 8'h11 * 8'(i + 1));
		for (int i = 0; i < 4; i++) begin
			op(1'b1, 9'h020 + 9'(i), 8'h00);
			check("hs byte", {24'h0, st[15:8]}, {24'h0, 8'h11 * 8'(i + 1)});
			check("hs lanes", {16'h0, dev_seen}, {24'h0, 8'h11 * 8'(i + 1)});
		end
		check("hs wait used", {31'h0, wait_seen}, 32'h1);
		check("hs no timeout", {30'h0, st[2:1]}, 32'h0);
		$display("test handshake done");
	endtask
	// blind reads over every status lane, then an early access
	task automatic t_blind;
		op(1'b0, 9'h1EF, 8'h01);
		check("blind mode", {31'h0, blind_mode_out}, 32'h1);
		wait_seen = 1'b0;
		for (int i = 0; i < 4; i++) begin
			op(1'b1, 9'h020 + 9'(i), 8'h00);
			check("dummy", {24'h0, st[15:8]}, {24'h0, `HP_DUMMY_BYTE});
			poll(9'h1F0 + 9'(i));
			check("done lane", {16'h0, dev_seen}, 32'h0080);
			op(1'b1, 9'h1F4 + 9'(i), 8'h00);
			check("holding", {24'h0, st[15:8]}, {24'h0, 8'h11 * 8'(i + 1)});
			op(1'b1, 9'h1F0 + 9'(i), 8'h00);
			check("done cleared", {24'h0, st[15:8]}, 32'h0);
			check("done out", {31'h0, done_flag_out}, 32'h0);
		end
		check("no wait", {31'h0, wait_seen}, 32'h0);
		op(1'b1, 9'h020, 8'h00);
		op(1'b1, 9'h021, 8'h00);
		check("invalid irq", {31'h0, intf.irq}, 32'h1);
		poll(9'h1F3);
		op(1'b0, 9'h1EB, 8'h01);
		check("irq cleared", {31'h0, intf.irq}, 32'h0);
		$display("test blind done");
	endtask
	// controller byte mode: upper lane, always blind
	task automatic t_mcu;
		op(1'b0, 9'h1EF, 8'h04);
		apb(1'b1, `HP_APB_CFG, 32'h64, st);
		check("mcu blind", {31'h0, blind_mode_out}, 32'h1);
		wait_seen = 1'b0;
		op(1'b1, 9'h023, 8'h00);
		poll(9'h1F0);
		op(1'b1, 9'h1F7, 8'h00);
		check("mcu byte", {24'h0, st[15:8]}, 32'h44);
		check("mcu lanes", {16'h0, dev_seen}, 32'h4400);
		check("mcu no wait", {31'h0, wait_seen}, 32'h0);
		$display("test controller mode done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge clk_in);
		err_total++;
		final_report;
	end
	// reset, then the scenarios in order
	initial begin
		srst_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0;
		wait_seen = 1'b0;
		err_total = 0;
		n_checks = 0;
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		t_handshake;
		t_blind;
		t_mcu;
		final_report;
	end
endmodule
